// *** pkg/t16b_pkg.sv ***
// Constants and carrier types for the timer 16-bit byte access block.
package t16b_pkg;

  // ----------------------------------------------------------------
  // Byte locations on the 8-bit data bus
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_COUNT_LO = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h1;
  localparam logic [3:0] ADDR_CAPT_LO = 4'h2;
  localparam logic [3:0] ADDR_CAPT_HI = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
  localparam logic [3:0] ADDR_CMPB_LO = 4'h6;
  localparam logic [3:0] ADDR_CMPB_HI = 4'h7;
  localparam logic [3:0] ADDR_CTRL_A = 4'h8;
  localparam logic [3:0] ADDR_CTRL_B = 4'h9;
  localparam logic [3:0] ADDR_CTRL_C = 4'ha;

  // ----------------------------------------------------------------
  // Field positions inside the control registers
  // ----------------------------------------------------------------
  localparam int POS_WAVE_BIT0 = 0;
  localparam int POS_WAVE_BIT1 = 1;
  localparam int POS_WAVE_BIT2 = 3;
  localparam int POS_WAVE_BIT3 = 4;
  localparam int POS_FORCE_A = 7;
  localparam int POS_FORCE_B = 6;

  // ----------------------------------------------------------------
  // Counter values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_FIXED_8 = 16'h00ff;
  localparam logic [15:0] TOP_FIXED_9 = 16'h01ff;
  localparam logic [15:0] TOP_FIXED_10 = 16'h03ff;
  localparam logic [15:0] RST_WIDE = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Source of the count sequence's highest value.
  typedef enum logic [2:0]
  {
    TOP_SEL_MAX = 3'h0,
    TOP_SEL_F8 = 3'h1,
    TOP_SEL_F9 = 3'h2,
    TOP_SEL_F10 = 3'h3,
    TOP_SEL_CMPA = 3'h4,
    TOP_SEL_CAPT = 3'h5
  } t16b_top_sel_t;

  // One byte request from the processor core.
  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } t16b_bus_req_t;

  // Counter position flags.
  typedef struct packed
  {
    logic at_bottom;
    logic at_max;
    logic at_top;
  } t16b_flags_t;

endpackage

// *** rtl/t16b_timer.sv ***
// Byte-wide access path to the 16-bit registers of a timer/counter.
//
// Functional notes
// [R1] Count zero means counter at bottom.
// [R2] Count all ones means counter at max.
// [R3] Top is fixed, compare A or capture.
// [R4] Master moves wide registers as two bytes.
// [R5] One shared high-byte holding register per timer.
// [R6] Only low byte access moves wide data.
// [R7] Low write loads holding plus written byte.
// [R8] Low read copies high byte into holding.
// [R9] Compare reads bypass holding register entirely.
// [R10] Master writes high first, reads low first.
// [R11] Master guards two-byte sequences against interrupts.
// [R12] Wave bits 0-2 replace legacy pulse/clear bits.
// [R13] Force bits in C, wave bit 3 in B.
// [R14] Bus count write beats clear and count.
// [R15] Holding register clears on reset.
`timescale 1ns/1ps

module t16b_timer
  import t16b_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire t16b_bus_req_t BUS_REQ,
  output logic [7:0] BUS_RDATA,
  input wire logic COUNT_INC,
  input wire logic COUNT_CLR,
  input wire logic CAPTURE,
  output logic [15:0] COUNT,
  output logic [15:0] TOP_VALUE,
  output t16b_flags_t FLAGS,
  output logic [3:0] WAVE_MODE,
  output logic FORCE_A,
  output logic FORCE_B
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] count;
  logic [15:0] cmpa;
  logic [15:0] cmpb;
  logic [15:0] capt;
  logic [7:0] hold;
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] rdata;
  logic force_a;
  logic force_b;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic wr = BUS_REQ.wr & CE;
  wire logic rd = BUS_REQ.rd & CE;
  wire logic [3:0] addr = BUS_REQ.addr;
  wire logic [7:0] wdata = BUS_REQ.wdata;

  // Any high byte location only ever reaches the holding register.
  wire logic hi_loc = (addr == ADDR_COUNT_HI) | (addr == ADDR_CAPT_HI)
                    | (addr == ADDR_CMPA_HI) | (addr == ADDR_CMPB_HI);
  wire logic wr_hold = wr & hi_loc; // see [R5] [R6]
  wire logic wr_count = wr & (addr == ADDR_COUNT_LO); // see [R6]
  wire logic wr_cmpa = wr & (addr == ADDR_CMPA_LO);
  wire logic wr_cmpb = wr & (addr == ADDR_CMPB_LO);
  wire logic wr_capt = wr & (addr == ADDR_CAPT_LO);
  wire logic wr_ctrl_a = wr & (addr == ADDR_CTRL_A);
  wire logic wr_ctrl_b = wr & (addr == ADDR_CTRL_B);
  wire logic wr_ctrl_c = wr & (addr == ADDR_CTRL_C);
  wire logic rd_count_lo = rd & (addr == ADDR_COUNT_LO);
  wire logic rd_capt_lo = rd & (addr == ADDR_CAPT_LO);

  // Low byte writes join the holding byte with the bus byte.
  wire logic [15:0] wide_wdata = {hold, wdata}; // see [R7]

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Wave bits 0 and 1 sit where the legacy pulse bits were, bit 2
  // where the legacy clear-on-match bit was, bit 3 was added in B.
  wire logic wave_mode_bit0 = ctrl_a[POS_WAVE_BIT0]; // see [R12]
  wire logic wave_mode_bit1 = ctrl_a[POS_WAVE_BIT1]; // see [R12]
  wire logic wave_mode_bit2 = ctrl_b[POS_WAVE_BIT2]; // see [R12]
  wire logic wave_mode_bit3 = ctrl_b[POS_WAVE_BIT3]; // see [R13]
  wire logic [3:0] wave_mode = {wave_mode_bit3, wave_mode_bit2,
                                wave_mode_bit1, wave_mode_bit0};

  // A control write must show in the wave mode one edge later.
  wave_low_a: assert property (@(posedge CLK) // see [R12]
    disable iff (!RST_B)
    (CE && BUS_REQ.wr && BUS_REQ.addr == ADDR_CTRL_A)
    |=> (WAVE_MODE[1:0] == $past(BUS_REQ.wdata[1:0])))
    else $error("Control A write did not set wave bits 0 and 1.");

  wave_high_a: assert property (@(posedge CLK) // see [R12] [R13]
    disable iff (!RST_B)
    (CE && BUS_REQ.wr && BUS_REQ.addr == ADDR_CTRL_B)
    |=> (WAVE_MODE[3:2] == $past(BUS_REQ.wdata[4:3])))
    else $error("Control B write did not set wave bits 2 and 3.");

  // Maps the wave mode to the source of the top value.
  function automatic t16b_top_sel_t top_sel_of(input logic [3:0] m);
    t16b_top_sel_t s;
    s = TOP_SEL_MAX;
    unique case (m)
      4'h1, 4'h5: s = TOP_SEL_F8;
      4'h2, 4'h6: s = TOP_SEL_F9;
      4'h3, 4'h7: s = TOP_SEL_F10;
      4'h4, 4'h9, 4'hb, 4'hf: s = TOP_SEL_CMPA;
      4'h8, 4'ha, 4'hc, 4'he: s = TOP_SEL_CAPT;
      4'h0, 4'hd: s = TOP_SEL_MAX;
    endcase
    return s;
  endfunction

  wire t16b_top_sel_t top_sel = top_sel_of(wave_mode);
  wire logic [15:0] top_value =
    (top_sel == TOP_SEL_F8) ? TOP_FIXED_8 :
    (top_sel == TOP_SEL_F9) ? TOP_FIXED_9 :
    (top_sel == TOP_SEL_F10) ? TOP_FIXED_10 :
    (top_sel == TOP_SEL_CMPA) ? cmpa :
    (top_sel == TOP_SEL_CAPT) ? capt : CNT_MAX; // see [R3]

  // Spot checks of the top source, one fixed and one capture mode.
  top_fixed_a: assert property (@(posedge CLK) // see [R3]
    disable iff (!RST_B)
    (WAVE_MODE == 4'h2) |-> (TOP_VALUE == 16'h01ff))
    else $error("Fixed nine-bit top not selected.");

  top_capture_a: assert property (@(posedge CLK) // see [R3]
    disable iff (!RST_B)
    (WAVE_MODE == 4'he) |-> (TOP_VALUE == capt))
    else $error("Capture value not used as top.");

  // The capture value is only writable while it defines the top,
  // otherwise the capture event owns it.
  wire logic capt_is_top = (top_sel == TOP_SEL_CAPT);

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // A bus write wins over clear and count in the same cycle.
  wire logic [15:0] next_count =
    wr_count ? wide_wdata : // see [R14]
    COUNT_CLR ? CNT_BOTTOM :
    COUNT_INC ? 16'(count + 16'h0001) : count;

  wire logic [15:0] next_capt =
    (wr_capt & capt_is_top) ? wide_wdata :
    (CAPTURE & ~capt_is_top) ? count : capt;

  // Low reads of count and capture load their upper byte into the
  // holding register; compare reads leave it alone.
  wire logic [7:0] next_hold =
    wr_hold ? wdata :
    rd_count_lo ? count[15:8] : // see [R8]
    rd_capt_lo ? capt[15:8] : hold; // see [R8] [R9]

  // Read selection: high count and capture bytes come from holding.
  wire logic [7:0] read_byte =
    (addr == ADDR_COUNT_LO) ? count[7:0] :
    (addr == ADDR_COUNT_HI) ? hold : // see [R8]
    (addr == ADDR_CAPT_LO) ? capt[7:0] :
    (addr == ADDR_CAPT_HI) ? hold :
    (addr == ADDR_CMPA_LO) ? cmpa[7:0] :
    (addr == ADDR_CMPA_HI) ? cmpa[15:8] : // see [R9]
    (addr == ADDR_CMPB_LO) ? cmpb[7:0] :
    (addr == ADDR_CMPB_HI) ? cmpb[15:8] : // see [R9]
    (addr == ADDR_CTRL_A) ? ctrl_a :
    (addr == ADDR_CTRL_B) ? ctrl_b : RST_BYTE;

  // ----------------------------------------------------------------
  // Wide registers
  // ----------------------------------------------------------------
  // One edge loads all sixteen bits so no half-written value is seen.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      count <= RST_WIDE;
      capt <= RST_WIDE;
      cmpa <= RST_WIDE;
      cmpb <= RST_WIDE;
    end
    else if (CE)
    begin
      count <= next_count; // see [R14]
      capt <= next_capt;
      if (wr_cmpa)
        cmpa <= wide_wdata; // see [R7]
      if (wr_cmpb)
        cmpb <= wide_wdata; // see [R7]
    end
  end

  // Low writes load sixteen bits; a high write alone moves nothing wide.
  low_write_a: assert property (@(posedge CLK) // see [R7]
    disable iff (!RST_B)
    (CE && BUS_REQ.wr && BUS_REQ.addr == ADDR_CMPB_LO)
    |=> (cmpb == {$past(hold), $past(BUS_REQ.wdata)}))
    else $error("Low byte write did not load the wide register.");

  high_write_a: assert property (@(posedge CLK) // see [R6]
    disable iff (!RST_B)
    (CE && BUS_REQ.wr && BUS_REQ.addr == ADDR_CMPA_HI)
    |=> ($stable(cmpa) && hold == $past(BUS_REQ.wdata)))
    else $error("High byte write touched more than holding.");

  write_wins_a: assert property (@(posedge CLK) // see [R14]
    disable iff (!RST_B)
    (wr_count && (COUNT_CLR || COUNT_INC))
    |=> (COUNT == {$past(hold), $past(BUS_REQ.wdata)}))
    else $error("Count write lost to clear or count.");

  // Holding register, control bytes and registered read data.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      hold <= RST_BYTE; // see [R15]
      ctrl_a <= RST_BYTE;
      ctrl_b <= RST_BYTE;
      rdata <= RST_BYTE;
    end
    else if (CE)
    begin
      hold <= next_hold; // see [R5]
      if (wr_ctrl_a)
        ctrl_a <= wdata;
      if (wr_ctrl_b)
        ctrl_b <= wdata;
      if (rd)
        rdata <= read_byte;
    end
  end

  // Holding traffic for low reads, high reads and compare reads.
  low_read_a: assert property (@(posedge CLK) // see [R8]
    disable iff (!RST_B)
    (CE && BUS_REQ.rd && BUS_REQ.addr == ADDR_COUNT_LO && !wr_hold)
    |=> (hold == $past(COUNT[15:8])))
    else $error("Low byte read did not fill holding.");

  capt_read_a: assert property (@(posedge CLK) // see [R8]
    disable iff (!RST_B)
    (CE && BUS_REQ.rd && BUS_REQ.addr == ADDR_CAPT_LO)
    |=> (hold == $past(capt[15:8])))
    else $error("Capture low read did not fill holding.");

  high_read_a: assert property (@(posedge CLK) // see [R8]
    disable iff (!RST_B)
    (CE && BUS_REQ.rd && BUS_REQ.addr == ADDR_COUNT_HI)
    |=> (BUS_RDATA == $past(hold)))
    else $error("Count high read did not return holding.");

  cmp_read_a: assert property (@(posedge CLK) // see [R9]
    disable iff (!RST_B)
    (CE && BUS_REQ.rd && !BUS_REQ.wr && BUS_REQ.addr == ADDR_CMPA_HI)
    |=> ($stable(hold) && BUS_RDATA == $past(cmpa[15:8])))
    else $error("Compare read used the holding register.");

  cmpb_read_a: assert property (@(posedge CLK) // see [R9]
    disable iff (!RST_B)
    (CE && BUS_REQ.rd && !BUS_REQ.wr && BUS_REQ.addr == ADDR_CMPB_LO)
    |=> ($stable(hold) && BUS_RDATA == $past(cmpb[7:0])))
    else $error("Compare B read disturbed the holding register.");

  hold_reset_a: assert property (@(posedge CLK) // see [R15]
    $rose(RST_B) |-> (hold == 8'h00))
    else $error("Holding register not cleared by reset.");

  // Force strobes: a written one gives a single-cycle pulse; the
  // bits are not stored, so control C always reads as zero.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      force_a <= 1'h0;
      force_b <= 1'h0;
    end
    else if (CE)
    begin
      force_a <= wr_ctrl_c & wdata[POS_FORCE_A]; // see [R13]
      force_b <= wr_ctrl_c & wdata[POS_FORCE_B]; // see [R13]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BUS_RDATA = rdata;
  assign COUNT = count;
  assign TOP_VALUE = top_value;
  assign WAVE_MODE = wave_mode;
  assign FORCE_A = force_a;
  assign FORCE_B = force_b;
  // One assignment drives the whole flag struct, so it has one driver.
  assign FLAGS = '{
    at_bottom: (count == CNT_BOTTOM), // see [R1]
    at_max: (count == CNT_MAX), // see [R2]
    at_top: (count == top_value) // see [R3]
  };

  // Flags track the count; a clear lands on bottom; forces pulse.
  bottom_flag_a: assert property (@(posedge CLK) // see [R1]
    disable iff (!RST_B)
    FLAGS.at_bottom == (COUNT == 16'h0000))
    else $error("Bottom flag disagrees with count.");

  max_flag_a: assert property (@(posedge CLK) // see [R2]
    disable iff (!RST_B)
    FLAGS.at_max == (COUNT == 16'hffff))
    else $error("Max flag disagrees with count.");

  clear_bottom_a: assert property (@(posedge CLK) // see [R1]
    disable iff (!RST_B)
    (CE && COUNT_CLR && !wr_count) |=> FLAGS.at_bottom)
    else $error("Clear did not bring the count to bottom.");

  force_pulse_a: assert property (@(posedge CLK) // see [R13]
    disable iff (!RST_B)
    (CE && BUS_REQ.wr && BUS_REQ.addr == ADDR_CTRL_C)
    |=> (FORCE_A == $past(BUS_REQ.wdata[7])
         && FORCE_B == $past(BUS_REQ.wdata[6])))
    else $error("Control C write did not pulse the force outputs.");

endmodule

// *** dv/t16b_core_model.sv ***
// Processor core model that moves bytes over the timer data bus.
`timescale 1ns/1ps
module t16b_core_model
  import t16b_pkg::*;
(
  input wire logic clk,
  output t16b_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata
);
  // -------------------------------------------------------------
  // Byte and wide transfers
  // -------------------------------------------------------------
  // Idle bus carries no strobe; data is inverted so nothing stale shows.
  initial
  begin
    bus_req = '0;
  end

  // One byte, launched at an edge, taken at the next, answer read then.
  task automatic acc(input logic rd, input logic wr, input logic [3:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    bus_req <= '{rd, wr, a, d};
    @(posedge clk);
    bus_req <= '{1'h0, 1'h0, a, ~d};
    #1 q = bus_rdata;
  endtask

  // Wide write, high byte first, as two byte transfers.
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    logic [7:0] q;
    acc(1'h0, 1'h1, lo + 4'h1, v[15:8], q);
    acc(1'h0, 1'h1, lo, v[7:0], q);
  endtask

  // Wide read, low byte first; no handler ever interleaves a sequence.
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    acc(1'h1, 1'h0, lo, 8'h00, v[7:0]);
    acc(1'h1, 1'h0, lo + 4'h1, 8'h00, v[15:8]);
  endtask
endmodule

// *** dv/test_timer16_byte_access.sv ***
// Self-checking testbench for the timer 16-bit byte access block.
`timescale 1ns/1ps
module test_timer16_byte_access
  import t16b_pkg::*;
;
  logic CLK, RST_B, CE, COUNT_INC, COUNT_CLR, CAPTURE, FORCE_A, FORCE_B;
  t16b_bus_req_t BUS_REQ;
  t16b_flags_t FLAGS;
  logic [7:0] BUS_RDATA, b;
  logic [3:0] WAVE_MODE;
  logic [15:0] COUNT, TOP_VALUE, v, r, cmpa, cap, exp;
  logic [15:0] seed = 16'h2ad4;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  t16b_timer t16b_timer_inst (.CLK(CLK), .RST_B(RST_B), .CE(CE),
    .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA), .COUNT_INC(COUNT_INC),
    .COUNT_CLR(COUNT_CLR), .CAPTURE(CAPTURE), .COUNT(COUNT),
    .TOP_VALUE(TOP_VALUE), .FLAGS(FLAGS), .WAVE_MODE(WAVE_MODE),
    .FORCE_A(FORCE_A), .FORCE_B(FORCE_B));
  t16b_core_model t16b_core_model_inst (.clk(CLK), .bus_req(BUS_REQ),
    .bus_rdata(BUS_RDATA));

  // -------------------------------------------------------------
  // Clock, timeout and helpers
  // -------------------------------------------------------------
  // Free-running 25 MHz clock.
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // A hang is cut short well beyond the roughly 170 cycles needed.
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      results();
    end
  end

  // Repeatable pseudo-random source.
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // Expected top for each wave mode.
  function automatic logic [15:0] top_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: return TOP_FIXED_8;
      4'h2, 4'h6: return TOP_FIXED_9;
      4'h3, 4'h7: return TOP_FIXED_10;
      4'h4, 4'h9, 4'hb, 4'hf: return cmpa;
      4'h8, 4'ha, 4'hc, 4'he: return cap;
      default: return CNT_MAX;
    endcase
  endfunction

  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] w);
    cmp_count++;
    if (s !== w)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, w, s);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    RST_B = 1'b0;
    CE = 1'b1;
    COUNT_INC = 1'b0;
    COUNT_CLR = 1'b0;
    CAPTURE = 1'b0;
    cap = RST_WIDE;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    #1 chk("bottom", {15'h0, FLAGS.at_bottom}, 16'h1);
    t16b_core_model_inst.acc(1'b1, 1'b0, ADDR_COUNT_HI, 8'h00, b);
    chk("hold reset", {8'h0, b}, {8'h0, RST_BYTE});
    // A lone high write must leave the count alone.
    v = rnd();
    t16b_core_model_inst.acc(1'b0, 1'b1, ADDR_COUNT_HI, v[15:8], b);
    chk("count high only", COUNT, RST_WIDE);
    t16b_core_model_inst.acc(1'b0, 1'b1, ADDR_COUNT_LO, v[7:0], b);
    chk("count wide", COUNT, v);
    // The holding byte is reused by compare A without a new high write.
    cmpa = {v[15:8], ~v[7:0]};
    t16b_core_model_inst.acc(1'b0, 1'b1, ADDR_CMPA_LO, cmpa[7:0], b);
    t16b_core_model_inst.acc(1'b0, 1'b1, ADDR_COUNT_HI, ~v[15:8], b);
    t16b_core_model_inst.rd16(ADDR_CMPA_LO, r);
    chk("compare direct", r, cmpa);
    t16b_core_model_inst.acc(1'b1, 1'b0, ADDR_COUNT_HI, 8'h00, b);
    chk("hold kept", {8'h0, b}, {8'h0, ~v[15:8]});
    t16b_core_model_inst.rd16(ADDR_COUNT_LO, r);
    chk("count read", r, v);
    // Compare B loads through holding; its reads leave holding alone.
    r = rnd();
    t16b_core_model_inst.wr16(ADDR_CMPB_LO, r);
    t16b_core_model_inst.rd16(ADDR_CMPB_LO, v);
    chk("compare b", v, r);
    t16b_core_model_inst.acc(1'h1, 1'h0, ADDR_COUNT_HI, 8'h00, b);
    chk("hold after b", {8'h0, b}, {8'h0, r[15:8]});
    // A bus write beats clear and increment in the same cycle.
    @(posedge CLK);
    COUNT_INC <= 1'b1;
    COUNT_CLR <= 1'b1;
    t16b_core_model_inst.wr16(ADDR_COUNT_LO, CNT_MAX);
    chk("write wins", COUNT, CNT_MAX);
    chk("max", {15'h0, FLAGS.at_max}, 16'h1);
    @(posedge CLK);
    COUNT_INC <= 1'b0;
    COUNT_CLR <= 1'b0;
    #1 chk("clear", COUNT, CNT_BOTTOM);
    // Random counting with clock-enable gaps and captures.
    exp = CNT_BOTTOM;
    v = 16'h0003;
    for (int i = 0; i <= 40; i++)
    begin
      @(posedge CLK);
      if (v[0] | v[1])
      begin
        cap = (v[6] & v[7]) ? exp : cap;
        exp = (v[3] & v[4]) ? CNT_BOTTOM : exp + {15'h0, v[2]};
      end
      v = (i < 40) ? rnd() : 16'h0003;
      CE <= v[0] | v[1];
      COUNT_INC <= v[2];
      COUNT_CLR <= v[3] & v[4];
      CAPTURE <= v[6] & v[7];
      #1 chk("count", COUNT, exp);
    end
    t16b_core_model_inst.rd16(ADDR_CAPT_LO, r);
    chk("capture read", r, cap);
    for (int k = 0; k < 2; k++)
    begin
      t16b_core_model_inst.acc(1'b0, 1'b1, ADDR_CTRL_C, 8'h80 >> k, b);
      chk("force", {14'h0, FORCE_A, FORCE_B}, 16'h2 >> k);
    end
    // A fresh compare A through its own high byte feeds the top modes.
    cmpa = rnd();
    t16b_core_model_inst.wr16(ADDR_CMPA_LO, cmpa);
    t16b_core_model_inst.rd16(ADDR_CMPA_LO, r);
    chk("compare a", r, cmpa);
    // Every wave mode; a capture write is refused in mode 0, since the
    // capture value is not the top there, and taken in mode 14.
    for (int m = 0; m < 16; m++)
    begin
      v = 16'(m);
      t16b_core_model_inst.acc(1'b0, 1'b1, ADDR_CTRL_A, {6'h0, v[1:0]}, b);
      t16b_core_model_inst.acc(1'b0, 1'b1, ADDR_CTRL_B,
        {3'h0, v[3], v[2], 3'h0}, b);
      if (m == 0)
        t16b_core_model_inst.wr16(ADDR_CAPT_LO, ~cap);
      if (m == 14)
      begin
        cap = rnd();
        t16b_core_model_inst.wr16(ADDR_CAPT_LO, cap);
      end
      chk("wave mode", {12'h0, WAVE_MODE}, v);
      chk("top", TOP_VALUE, top_of(v[3:0]));
    end
    t16b_core_model_inst.wr16(ADDR_COUNT_LO, cmpa);
    chk("at top", {15'h0, FLAGS.at_top}, 16'h1);
    results();
  end
endmodule
